// File: octal_switch_map.svh
/*
  constants for the octal switch channel control: config defaults, channel
  count and protection timing, expressed in core clock cycles.
  assumes a 100 MHz core clock.
*/
`ifndef OCTAL_SWITCH_MAP_SVH
`define OCTAL_SWITCH_MAP_SVH

`define OSW_CHANNELS        8
`define OSW_PAR_CHANNELS    4
`define OSW_MAPPED_CH       3
`define OSW_MAP_DEFAULT     8'h08
`define OSW_CFG_DEFAULT     8'h00
`define OSW_CLK_MHZ         100
`define OSW_FAULT_FILTER_US 100
`define OSW_OVL_OFF_US      10
`define OSW_SLEW_FAST_US    15
`define OSW_SLEW_SLOW_US    60
`define OSW_FAULT_FILTER_CYC (`OSW_FAULT_FILTER_US * `OSW_CLK_MHZ)
`define OSW_OVL_OFF_CYC     (`OSW_OVL_OFF_US * `OSW_CLK_MHZ)
`define OSW_SLEW_FAST_CYC   (`OSW_SLEW_FAST_US * `OSW_CLK_MHZ)
`define OSW_SLEW_SLOW_CYC   (`OSW_SLEW_SLOW_US * `OSW_CLK_MHZ)
`define OSW_CNT_W           16

`endif

// File: octal_switch_pkg.sv
/*
  types shared by the octal switch channel control.
  assumes nothing beyond the map header.
*/
package octal_switch_pkg;

  typedef struct packed {
    logic [7:0] input_map;
    logic [7:0] combine_operation_config;
    logic [7:0] overload_behaviour_config;
    logic [7:0] overtemp_behaviour_config;
    logic [7:0] slew_select_config;
  } channel_cfg_t;

  typedef struct packed {
    logic overtemp;
    logic overload;
  } channel_diag_t;

  typedef enum logic [1:0] {
    CH_OFF,
    CH_ON,
    CH_OT_WAIT,
    CH_OVL_LATCH
  } channel_state_t;

endpackage

// File: channel_protect.sv
/*
  one output channel: protection state machine, overload timers and slew
  timer. assumes synchronous inputs and a combined command computed outside.
*/
`timescale 1ns/1ns
`default_nettype none
`include "octal_switch_map.svh"

module channel_protect #(
  parameter int FAULT_FILTER_CYC = `OSW_FAULT_FILTER_CYC,
  parameter int OVL_OFF_CYC      = `OSW_OVL_OFF_CYC,
  parameter int SLEW_FAST_CYC    = `OSW_SLEW_FAST_CYC,
  parameter int SLEW_SLOW_CYC    = `OSW_SLEW_SLOW_CYC
) (
  // clock and reset
  input  wire logic                           i_core_clk,
  input  wire logic                           i_reset_n,
  input  wire logic                           i_sleep,
  input  wire logic                           i_diag_clear,
  // control
  input  wire logic                           i_cmd,
  input  wire logic                           i_cmd_rise,
  input  wire logic                           i_overtemp_latching,
  input  wire logic                           i_overload_shutdown,
  input  wire logic                           i_slow_slew,
  // sensors
  input  wire logic                           i_overtemp_sense,
  input  wire logic                           i_current_limit,
  // results
  output logic                                o_gate,
  output logic                                o_switching,
  output octal_switch_pkg::channel_diag_t     o_diag
);

  octal_switch_pkg::channel_state_t state_reg;
  octal_switch_pkg::channel_state_t state_next;
  logic [`OSW_CNT_W-1:0] limit_cnt_reg;
  logic [`OSW_CNT_W-1:0] slew_cnt_reg;
  logic                  gate_reg;
  logic                  ot_flag_reg;
  logic                  ovl_flag_reg;

  wire ot_trip     = (state_reg == octal_switch_pkg::CH_ON) & i_overtemp_sense;
  wire ovl_trip    = i_overload_shutdown & (limit_cnt_reg >= OVL_OFF_CYC[`OSW_CNT_W-1:0]);
  wire filter_trip = limit_cnt_reg >= FAULT_FILTER_CYC[`OSW_CNT_W-1:0];
  wire [`OSW_CNT_W-1:0] slew_load = i_slow_slew ? SLEW_SLOW_CYC[`OSW_CNT_W-1:0]
                                                : SLEW_FAST_CYC[`OSW_CNT_W-1:0];

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      octal_switch_pkg::CH_OFF: begin
        if (i_cmd) begin
          state_next = octal_switch_pkg::CH_ON;
        end
      end
      octal_switch_pkg::CH_ON: begin
        if (ot_trip) begin
          state_next = octal_switch_pkg::CH_OT_WAIT;
        end else if (ovl_trip) begin
          state_next = octal_switch_pkg::CH_OVL_LATCH;
        end else if (!i_cmd) begin
          state_next = octal_switch_pkg::CH_OFF;
        end
      end
      octal_switch_pkg::CH_OT_WAIT: begin
        // latching waits for a fresh rising command; auto-restart waits for cooling
        if (i_overtemp_latching) begin
          if (i_cmd_rise) begin
            state_next = octal_switch_pkg::CH_ON;
          end
        end else if (!i_overtemp_sense) begin
          state_next = i_cmd ? octal_switch_pkg::CH_ON : octal_switch_pkg::CH_OFF;
        end
      end
      octal_switch_pkg::CH_OVL_LATCH: begin
        if (i_cmd_rise) begin
          state_next = octal_switch_pkg::CH_ON;
        end
      end
    endcase
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n || i_sleep) begin
      state_reg <= octal_switch_pkg::CH_OFF;
    end else begin
      state_reg <= state_next;
    end
  end

  // current limit duration, counted only while conducting
  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n || i_sleep || state_reg != octal_switch_pkg::CH_ON || !i_current_limit) begin
      limit_cnt_reg <= '0;
    end else if (limit_cnt_reg != {`OSW_CNT_W{1'b1}}) begin
      limit_cnt_reg <= limit_cnt_reg + 1'b1;
    end
  end

  wire gate_next = (state_next == octal_switch_pkg::CH_ON);

  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n || i_sleep) begin
      gate_reg     <= 1'b0;
      slew_cnt_reg <= '0;
    end else begin
      gate_reg <= gate_next;
      if (gate_next != gate_reg) begin
        slew_cnt_reg <= slew_load;
      end else if (slew_cnt_reg != '0) begin
        slew_cnt_reg <= slew_cnt_reg - 1'b1;
      end
    end
  end

  // set wins over the clear so an event in the clearing cycle survives
  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n || i_sleep) begin
      ot_flag_reg  <= 1'b0;
      ovl_flag_reg <= 1'b0;
    end else begin
      ot_flag_reg  <= ot_trip | (ot_flag_reg & ~i_diag_clear);
      ovl_flag_reg <= (state_reg == octal_switch_pkg::CH_ON & (ovl_trip | filter_trip))
                      | (ovl_flag_reg & ~i_diag_clear);
    end
  end

  assign o_gate          = gate_reg;
  assign o_switching     = slew_cnt_reg != '0;
  assign o_diag.overtemp = ot_flag_reg;
  assign o_diag.overload = ovl_flag_reg;

endmodule
`default_nettype wire

// File: octal_switch_channel_control.sv
/*
  eight-channel low-side switch control: combines serial bits with parallel
  inputs, maps the fourth parallel input, and runs per-channel protection.
  assumes configuration words arrive already decoded from the serial link,
  pins synchronous to i_core_clk, and the reset pin as an active low level.
*/
`timescale 1ns/1ns
`default_nettype none
`include "octal_switch_map.svh"

module octal_switch_channel_control (
  // clock and reset
  input  wire logic                                i_core_clk,
  input  wire logic                                i_reset_n,
  // device pins
  input  wire logic                                i_reset_pin_n,
  input  wire logic                                i_input_polarity_pin,
  input  wire logic [2:0]                          i_parallel_in,
  input  wire logic                                i_mapped_parallel_input,
  // configuration from the serial link
  input  wire logic                                i_cfg_write,
  input  wire octal_switch_pkg::channel_cfg_t      i_cfg,
  input  wire logic                                i_cfg_defaults,
  input  wire logic                                i_onoff_write,
  input  wire logic [7:0]                          i_onoff,
  input  wire logic                                i_diag_clear,
  // sensors
  input  wire logic [7:0]                          i_overtemp_sense,
  input  wire logic [7:0]                          i_current_limit,
  // outputs
  output logic [7:0]                               o_gate,
  output logic [7:0]                               o_switching,
  output logic [7:0]                               o_onoff,
  output octal_switch_pkg::channel_cfg_t           o_cfg,
  output logic [15:0]                              o_diag,
  output logic                                     o_fault,
  output logic                                     o_sleep
);

  octal_switch_pkg::channel_cfg_t cfg_reg;
  logic [7:0]                     onoff_reg;
  logic [7:0]                     cmd_prev_reg;
  logic                           sleep_reg;
  octal_switch_pkg::channel_diag_t diag_w [`OSW_CHANNELS];

  wire sleep = ~i_reset_pin_n;

  function automatic logic active_level(input logic pin, input logic polarity);
    active_level = polarity ? pin : ~pin;
  endfunction

  wire [2:0] par_low;
  wire       mapped_act = active_level(i_mapped_parallel_input, i_input_polarity_pin);
  wire [7:0] par_act;
  wire [7:0] cmd;
  wire [7:0] cmd_rise;

  genvar g;
  generate
    for (g = 0; g < `OSW_PAR_CHANNELS - 1; g++) begin : g_par
      assign par_low[g] = active_level(i_parallel_in[g], i_input_polarity_pin);
    end
  endgenerate

  generate
    for (g = 0; g < `OSW_CHANNELS; g++) begin : g_ch
      // mapped input joins each channel's own parallel input where one exists
      if (g < `OSW_PAR_CHANNELS - 1) begin : g_own
        assign par_act[g] = par_low[g] | (cfg_reg.input_map[g] & mapped_act);
      end else begin : g_map
        assign par_act[g] = cfg_reg.input_map[g] & mapped_act;
      end
      assign cmd[g] = cfg_reg.combine_operation_config[g]
                    ? (par_act[g] & onoff_reg[g])
                    : (par_act[g] | onoff_reg[g]);
      assign cmd_rise[g] = cmd[g] & ~cmd_prev_reg[g];

      channel_protect u_channel (
        .i_core_clk          (i_core_clk),
        .i_reset_n           (i_reset_n),
        .i_sleep             (sleep),
        .i_diag_clear        (i_diag_clear),
        .i_cmd               (cmd[g]),
        .i_cmd_rise          (cmd_rise[g]),
        .i_overtemp_latching (cfg_reg.overtemp_behaviour_config[g]),
        .i_overload_shutdown (cfg_reg.overload_behaviour_config[g]),
        .i_slow_slew         (cfg_reg.slew_select_config[g]),
        .i_overtemp_sense    (i_overtemp_sense[g]),
        .i_current_limit     (i_current_limit[g]),
        .o_gate              (o_gate[g]),
        .o_switching         (o_switching[g]),
        .o_diag              (diag_w[g])
      );
      assign o_diag[2*g+1:2*g] = sleep ? 2'b00 : diag_w[g];
    end
  endgenerate

  // configuration survives sleep; only on/off is cleared so wake follows pins
  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n || i_cfg_defaults) begin
      cfg_reg.input_map                 <= `OSW_MAP_DEFAULT;
      cfg_reg.combine_operation_config  <= `OSW_CFG_DEFAULT;
      cfg_reg.overload_behaviour_config <= `OSW_CFG_DEFAULT;
      cfg_reg.overtemp_behaviour_config <= `OSW_CFG_DEFAULT;
      cfg_reg.slew_select_config        <= `OSW_CFG_DEFAULT;
    end else if (i_cfg_write && !sleep) begin
      cfg_reg <= i_cfg;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n || sleep || i_cfg_defaults) begin
      onoff_reg <= `OSW_CFG_DEFAULT;
    end else if (i_onoff_write) begin
      onoff_reg <= i_onoff;
    end
  end

  // previous command starts low: a command already on at release reads as an edge,
  // harmless because every channel leaves reset in the off state
  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      cmd_prev_reg <= 8'h00;
      sleep_reg    <= 1'b0;
    end else begin
      cmd_prev_reg <= cmd;
      sleep_reg    <= sleep;
    end
  end

  assign o_onoff = onoff_reg;
  assign o_cfg   = cfg_reg;
  assign o_fault = |o_diag;
  assign o_sleep = sleep_reg;

endmodule
`default_nettype wire

// File: octal_switch_channel_control_sva.sv
/*
  assertions on the octal switch channel control top ports.
  assumes one core clock and a synchronous active low reset.
*/
`timescale 1ns/1ns
`default_nettype none
module octal_switch_channel_control_sva (
  // clock and reset
  input  wire logic                           i_core_clk,
  input  wire logic                           i_reset_n,
  // pins and sensors
  input  wire logic                           i_reset_pin_n,
  input  wire logic [7:0]                     i_overtemp_sense,
  input  wire logic [7:0]                     i_current_limit,
  // outputs watched
  input  wire logic [7:0]                     o_gate,
  input  wire logic [7:0]                     o_switching,
  input  wire logic [7:0]                     o_onoff,
  input  wire octal_switch_pkg::channel_cfg_t o_cfg,
  input  wire logic [15:0]                    o_diag,
  input  wire logic                           o_fault
);
  // held current limit on channel one in shutdown mode, two cycles of slack
  logic [10:0] ovl_cnt_reg;
  logic [10:0] ovl_cnt_next;
  wire  logic  ovl_hold;
  assign ovl_hold = o_gate[0] && i_current_limit[0] && o_cfg.overload_behaviour_config[0];
  assign ovl_cnt_next = ovl_hold ? ovl_cnt_reg + 11'h001 : 11'h000;
  always_ff @(posedge i_core_clk) begin
    ovl_cnt_reg <= i_reset_n ? ovl_cnt_next : 11'h000;
  end

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_reset_n);

  sequence s_ot_trip;
    i_reset_pin_n && ((o_gate & i_overtemp_sense) != 8'h00);
  endsequence

  a_ot_shutoff: assert property (s_ot_trip |=> (o_gate & $past(o_gate & i_overtemp_sense)) == 8'h00)
    else $error("overheated channel stayed on");
  a_ot_only_on: assert property (!o_gate[2] && !o_diag[5] |=> !o_diag[5])
    else $error("overtemp flagged on an off channel");
  a_sleep_off: assert property (!i_reset_pin_n |=> o_gate == 8'h00 && o_onoff == 8'h00)
    else $error("outputs or on/off kept in sleep");
  a_sleep_diag: assert property (!i_reset_pin_n && !$past(i_reset_pin_n) |-> o_diag == 16'h0000)
    else $error("diagnosis shown in sleep");
  a_fault_any: assert property (o_fault == (o_diag != 16'h0000))
    else $error("fault flag disagrees with diagnosis");
  a_slew_flag: assert property ($changed(o_gate[0]) && $past(i_reset_pin_n) |-> o_switching[0])
    else $error("gate change without slew timer");
  a_ovl_delay: assert property (ovl_cnt_reg <= 11'h3ea)
    else $error("overload shutdown too late");
  a_reset_dflt: assert property (disable iff (1'b0) !i_reset_n |=> o_cfg == 40'h0800000000)
    else $error("config not at defaults after reset");
endmodule

bind octal_switch_channel_control octal_switch_channel_control_sva sva_i (
  .i_core_clk(i_core_clk), .i_reset_n(i_reset_n), .i_reset_pin_n(i_reset_pin_n),
  .i_overtemp_sense(i_overtemp_sense), .i_current_limit(i_current_limit),
  .o_gate(o_gate), .o_switching(o_switching), .o_onoff(o_onoff), .o_cfg(o_cfg),
  .o_diag(o_diag), .o_fault(o_fault)
);
`default_nettype wire

// File: mcu_model.sv
/*
  controller model: drives the device pins and the decoded serial writes.
  assumes the bench calls its tasks; changes land on the falling edge.
*/
`timescale 1ns/1ns
`default_nettype none
module mcu_model (
  // clock
  input  wire logic                      i_core_clk,
  // device pins
  output logic                           o_reset_pin_n,
  output logic                           o_input_polarity_pin,
  output logic [2:0]                     o_parallel_in,
  output logic                           o_mapped_parallel_input,
  // decoded serial writes
  output logic                           o_cfg_write,
  output octal_switch_pkg::channel_cfg_t o_cfg,
  output logic                           o_onoff_write,
  output logic [7:0]                     o_onoff,
  output logic                           o_diag_clear,
  output logic                           o_cfg_defaults
);
  initial begin
    {o_reset_pin_n, o_input_polarity_pin, o_parallel_in, o_mapped_parallel_input} = 6'h30;
    {o_cfg_write, o_onoff_write, o_diag_clear, o_cfg_defaults} = 4'h0;
    o_cfg = 40'h0800000000;
    o_onoff = 8'h00;
  end

  task automatic pins(input logic rst_n, input logic pol, input logic [2:0] par, input logic m);
    @(negedge i_core_clk);
    {o_reset_pin_n, o_input_polarity_pin, o_parallel_in, o_mapped_parallel_input} =
      {rst_n, pol, par, m};
  endtask

  // which: 0 config, 1 on/off, 2 diag clear, 3 defaults; data turns to garbage once released
  task automatic send(input logic [1:0] which, input logic [39:0] cfg, input logic [7:0] v);
    @(negedge i_core_clk);
    o_cfg = cfg;
    o_onoff = v;
    {o_cfg_write, o_onoff_write, o_diag_clear, o_cfg_defaults} =
      {which == 2'h0, which == 2'h1, which == 2'h2, which == 2'h3};
    @(negedge i_core_clk);
    {o_cfg_write, o_onoff_write, o_diag_clear, o_cfg_defaults} = 4'h0;
    o_cfg = ~cfg;
    o_onoff = ~v;
    repeat (20) @(negedge i_core_clk);
  endtask

  // a latched channel only restarts on a fresh rising command
  task automatic reedge(input logic [7:0] v, input logic [7:0] ch);
    send(2'h1, 40'h0, v & ~ch);
    send(2'h1, 40'h0, v);
  endtask

  task automatic settle;
    repeat (20000) @(negedge i_core_clk);
  endtask
endmodule
`default_nettype wire

// File: octal_switch_channel_control_bench.sv
/*
  self-checking bench: table of combine cases, then protection, sleep,
  reset and slew cases. assumes mcu_model for pins and serial writes.
*/
`timescale 1ns/1ns
`default_nettype none
module octal_switch_channel_control_bench;
  typedef struct packed {
    logic [7:0] comb;
    logic       pol;
    logic [2:0] par;
    logic       m;
    logic [7:0] map;
    logic [7:0] onoff;
    logic [7:0] gate;
  } row_t;
  logic                           i_core_clk = 1'b0;
  logic                           i_reset_n = 1'b0;
  logic [7:0]                     ot = 8'h00;
  logic [7:0]                     cl = 8'h00;
  wire logic                      pin_n, pol, m, cfg_wr, on_wr, dclr, dflt, fault, sleep_q;
  wire logic [2:0]                par;
  wire logic [7:0]                onoff, gate, sw, onq;
  wire logic [15:0]               diag;
  octal_switch_pkg::channel_cfg_t cfg, cfgq;
  int unsigned                    fail_count = 0, n_tests = 0, cycles = 0, sw_cnt = 0;
  row_t                           rows [6] = '{
    '{8'h00, 1'b1, 3'h0, 1'b0, 8'h08, 8'h00, 8'h00}, '{8'h00, 1'b1, 3'h5, 1'b1, 8'h08, 8'h80, 8'h8d},
    '{8'hff, 1'b1, 3'h3, 1'b1, 8'h08, 8'h0f, 8'h0b}, '{8'hf0, 1'b0, 3'h6, 1'b0, 8'hf8, 8'h30, 8'h39},
    '{8'h00, 1'b1, 3'h0, 1'b1, 8'h00, 8'h00, 8'h00}, '{8'h00, 1'b0, 3'h7, 1'b1, 8'hff, 8'h00, 8'h00}};

  mcu_model mcu (.i_core_clk(i_core_clk), .o_reset_pin_n(pin_n), .o_input_polarity_pin(pol),
    .o_parallel_in(par), .o_mapped_parallel_input(m), .o_cfg_write(cfg_wr), .o_cfg(cfg),
    .o_onoff_write(on_wr), .o_onoff(onoff), .o_diag_clear(dclr), .o_cfg_defaults(dflt));
  octal_switch_channel_control dut (.i_core_clk(i_core_clk), .i_reset_n(i_reset_n),
    .i_reset_pin_n(pin_n), .i_input_polarity_pin(pol), .i_parallel_in(par),
    .i_mapped_parallel_input(m), .i_cfg_write(cfg_wr), .i_cfg(cfg), .i_cfg_defaults(dflt),
    .i_onoff_write(on_wr), .i_onoff(onoff), .i_diag_clear(dclr), .i_overtemp_sense(ot),
    .i_current_limit(cl), .o_gate(gate), .o_switching(sw), .o_onoff(onq), .o_cfg(cfgq),
    .o_diag(diag), .o_fault(fault), .o_sleep(sleep_q));

  always #5 i_core_clk = ~i_core_clk;

  task automatic test_done;
    $display("tests %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  always @(posedge i_core_clk) begin
    cycles++;
    if (sw[0] === 1'b1) sw_cnt++;
    if (cycles == 60000) begin
      fail_count++;
      $display("unexpected at %0t: run hung", $time);
      test_done();
    end
  end

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic cfg_on(input logic [39:0] c, input logic [7:0] v);
    mcu.send(2'h0, c, 8'h00);
    mcu.send(2'h1, 40'h0, v);
  endtask

  task automatic wait_neg(input int unsigned n);
    repeat (n) @(negedge i_core_clk);
  endtask

  initial begin
    wait_neg(2);
    i_reset_n = 1'b1;
    foreach (rows[i]) begin
      mcu.pins(1'b1, rows[i].pol, rows[i].par, rows[i].m);
      cfg_on({rows[i].map, rows[i].comb, 24'h0}, rows[i].onoff);
      check(16'(gate), 16'(rows[i].gate));
    end
    $display("table done");
    mcu.pins(1'b1, 1'b1, 3'h0, 1'b0);
    cfg_on(40'h0800000100, 8'h03);
    ot = 8'h07;
    wait_neg(1);
    check(16'(gate), 16'h0000);
    ot = 8'h00;
    wait_neg(5);
    check(16'(gate), 16'h0002);
    check(diag, 16'h000a);
    mcu.reedge(8'h03, 8'h01);
    check(16'(gate), 16'h0003);
    mcu.send(2'h2, 40'h0, 8'h00);
    check(16'(fault), 16'h0000);
    $display("overtemp done");
    cfg_on(40'h0800010000, 8'h01);
    cl = 8'h01;
    wait_neg(900);
    check(16'(gate), 16'h0001);
    wait_neg(200);
    check({diag[7:0], gate}, 16'h0100);
    cl = 8'h00;
    mcu.reedge(8'h01, 8'h01);
    check(16'(gate), 16'h0001);
    cfg_on(40'h0800000000, 8'h01);
    mcu.send(2'h2, 40'h0, 8'h00);
    check(diag, 16'h0000);
    cl = 8'h01;
    mcu.settle();
    check({diag[7:0], gate}, 16'h0101);
    cl = 8'h00;
    $display("overload done");
    mcu.send(2'h1, 40'h0, 8'hff);
    mcu.pins(1'b0, 1'b1, 3'h1, 1'b0);
    wait_neg(2);
    check({diag[7:0], gate}, 16'h0000);
    check({7'h00, sleep_q, onq}, 16'h0100);
    mcu.pins(1'b1, 1'b1, 3'h1, 1'b0);
    wait_neg(3);
    check(16'(gate), 16'h0001);
    cfg_on(40'hf000000000, 8'h0f);
    mcu.send(2'h3, 40'h0, 8'h00);
    check({cfgq.input_map, onq}, 16'h0800);
    mcu.send(2'h0, 40'hf000000000, 8'h00);
    i_reset_n = 1'b0;
    wait_neg(2);
    i_reset_n = 1'b1;
    check(16'(cfgq.input_map), 16'h0008);
    $display("sleep and reset done");
    mcu.pins(1'b1, 1'b1, 3'h0, 1'b0);
    for (int i = 0; i < 2; i++) begin
      cfg_on({32'h08000000, 7'h00, i[0]}, 8'h00);
      wait_neg(6100);
      sw_cnt = 0;
      mcu.send(2'h1, 40'h0, 8'h01);
      wait_neg(6100);
      check(16'(sw_cnt - (i ? 6000 : 1500) + 1 <= 2), 16'h0001);
    end
    $display("slew done");
    test_done();
  end
endmodule
`default_nettype wire
